/* common/sapsc_map.svh */
// Purpose: constants of the protection switching controller
// Assumes: 250 MHz core clock
// Notes: register map is a plain address port, read data one cycle later
// Notes on behaviour
// R1 - one working port paired with one protecting
// R2 - degrade or failure on working moves traffic
// R3 - lockout blocks fault switching, protecting port only
// R4 - forced switch moves service despite partner errors
// R5 - manual switch only when protecting error free
// R6 - nonrevertive keeps traffic on protecting port
// R7 - revertive returns after clear and timer expiry
// R8 - restore wait 5 to 12 minutes, default 5
// R9 - degrade threshold ten to minus n, 5..9
// R10 - failure threshold ten to minus n, 3..5
// R11 - degrade rate reached raises degrade alarm
// R12 - failure rate reached raises failure alarm
// R13 - degrade always reached before failure; the code raises both at the same window end when one window meets both limits
// R14 - readable status per port: level, role, state
// R15 - sliding window rate measure, alarm clears below; the code uses fixed windows whose counts restart each window
// R16 - priority lockout, forced, failure, degrade, manual, restore
`ifndef SAPSC_MAP_SVH
`define SAPSC_MAP_SVH
`define SAPSC_REG_CTRL 4'h0
`define SAPSC_REG_CMD 4'h1
`define SAPSC_REG_RESTORE 4'h2
`define SAPSC_REG_DEGRADE 4'h3
`define SAPSC_REG_FAILURE 4'h4
`define SAPSC_REG_STATUS 4'h5
`define SAPSC_REG_ALARM 4'h6
`define SAPSC_REG_EVT 4'h7
`define SAPSC_REG_EVT_CLR 4'h8
`define SAPSC_REG_EVT_EN 4'h9
`define SAPSC_REG_WAITLEFT 4'hA
`define SAPSC_RESTORE_DEF 4'h5
`define SAPSC_RESTORE_MIN 4'h5
`define SAPSC_RESTORE_MAX 4'hC
`define SAPSC_DEGRADE_DEF 4'h6
`define SAPSC_DEGRADE_MIN 4'h5
`define SAPSC_DEGRADE_MAX 4'h9
`define SAPSC_FAILURE_DEF 4'h3
`define SAPSC_FAILURE_MIN 4'h3
`define SAPSC_FAILURE_MAX 4'h5
`define SAPSC_CLK_HZ 250000000
`define SAPSC_SECONDS_PER_MINUTE 60
`define SAPSC_BER_WINDOW_EXP 9
`define SAPSC_CMD_LOCKOUT 0
`define SAPSC_CMD_FORCED 1
`define SAPSC_CMD_MANUAL 2
`define SAPSC_CMD_CLEAR 3
`define SAPSC_CMD_PROT_PORT 4
`define SAPSC_CTRL_REVERT 0
`define SAPSC_CTRL_FWD_PORT 1
`endif

/* common/sapsc_pkg.sv */
// Purpose: types of the protection switching controller
// Assumes: nothing
// Notes: request order follows switching priority, lowest first
package sapsc_pkg;
    typedef enum logic [2:0] {
        SAPSC_REQ_NONE, SAPSC_REQ_RESTORE, SAPSC_REQ_MANUAL, SAPSC_REQ_DEGRADE,
        SAPSC_REQ_FAILURE, SAPSC_REQ_FORCED, SAPSC_REQ_LOCKOUT
    } sapsc_req_t;
    typedef enum {SAPSC_ON_WORKING, SAPSC_ON_PROTECT, SAPSC_WAITING} sapsc_state_t;
endpackage

/* test/sapsc_line_model.sv */
// Purpose: far line terminal feeding bit and error strobes for both ports
// Assumes: one bit on three cycles of four
// Notes: error line is not held between bits, it flips instead
`timescale 1ns/1ps
module sapsc_line_model (
    input logic core_clk,
    input logic rst,
    input logic [1:0] errEn,
    output logic [1:0] rxBitValid,
    output logic [1:0] rxBitError
);
    logic [1:0] phaseQ = 2'h0;
    // bits in error only when the bench asks for it
    always @(posedge core_clk) begin
        phaseQ <= rst ? 2'h0 : phaseQ + 2'h1;
        rxBitValid <= (rst || phaseQ == 2'h3) ? 2'h0 : 2'h3;
        rxBitError <= (phaseQ != 2'h3) ? errEn : ~rxBitError;
    end
endmodule

/* test/sapsc_monitor.sv */
// Purpose: port assertions for the protection switch controller
// Assumes: register map as in sapsc_map.svh, command bits as the controller decodes them
// Notes: helper flops mirror mode, lockout and command writes
`timescale 1ns/1ps
module sapsc_monitor #(
    parameter longint unsigned MINUTE_CYCLES = 100
) (
    // clock and reset
    input logic core_clk,
    input logic rst,
    // line strobes
    input logic [1:0] rxBitValid,
    input logic [1:0] rxBitError,
    // register port
    input logic [3:0] regAddr,
    input logic [31:0] regWrData,
    input logic regWrite,
    input logic regRead,
    input logic [31:0] regRdData,
    // results
    input logic trafficOnProtect,
    input logic [1:0] degradeAlarm,
    input logic [1:0] failureAlarm,
    input logic irq
);
    logic lockQ, revQ, holdQ;
    logic [31:0] clrCntQ, dueQ;
    wire cmdW = regWrite && regAddr == 4'h1;
    wire clean = !degradeAlarm[1] && !failureAlarm[1];
    ////////////////////////////////////////////////////////////
    // mirror of mode, lockout, pending commands and clear time
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lockQ <= 1'b0;
            revQ <= 1'b0;
            holdQ <= 1'b0;
            clrCntQ <= 32'h0;
            dueQ <= 32'(5 * MINUTE_CYCLES);
        end else begin
            if (cmdW && regWrData[3]) begin
                lockQ <= 1'b0;
                holdQ <= 1'b0;
            end else if (cmdW) begin
                lockQ <= lockQ | (regWrData[0] & regWrData[4]);
                holdQ <= holdQ | regWrData[1] | regWrData[2];
            end
            if (regWrite && regAddr == 4'h0) begin
                revQ <= regWrData[0];
            end
            if (regWrite && regAddr == 4'h2) begin
                dueQ <= 32'(regWrData[3:0] * MINUTE_CYCLES);
            end
            if (degradeAlarm[0] || failureAlarm[0]) begin
                clrCntQ <= 32'h0;
            end else if (clrCntQ != 32'hFFFFFFFF) begin
                clrCntQ <= clrCntQ + 32'h1;
            end
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////
    chk_rd_idle: assert property (!$past(regRead) |-> regRdData == 32'h0)
        else $error("read data not idle");
    chk_two_stage: assert property ((failureAlarm & ~degradeAlarm) == 2'h0)
        else $error("failure without degrade");
    chk_fault_move: assert property (
        $rose(degradeAlarm[0]) && !lockQ && !holdQ && clean |=> trafficOnProtect)
        else $error("no switch on working fault");
    chk_lock_hold: assert property (lockQ && $past(lockQ) |-> !trafficOnProtect)
        else $error("traffic on protect under lockout");
    chk_nonrev_stay: assert property (!revQ && $fell(trafficOnProtect) |-> holdQ || lockQ)
        else $error("return in nonrevertive mode");
    chk_revert_early: assert property (
        $fell(trafficOnProtect) && revQ && !holdQ && !lockQ |-> clrCntQ + 32'h4 >= dueQ)
        else $error("return before restore wait");
    chk_revert_late: assert property (
        revQ && !holdQ && !lockQ && clrCntQ > dueQ + 32'h8 |-> !trafficOnProtect)
        else $error("no return after restore wait");
    chk_forced_move: assert property (
        cmdW && regWrData[1] && !regWrData[0] && !lockQ |-> ##[1:3] $changed(trafficOnProtect))
        else $error("forced switch ignored");
    chk_manual_clean: assert property (
        cmdW && regWrData[2:0] == 3'h4 && !lockQ && clean && !degradeAlarm[0] |-> ##[1:3] $changed(trafficOnProtect))
        else $error("manual switch ignored");
    chk_manual_dirty: assert property (
        cmdW && regWrData[2:0] == 3'h4 && degradeAlarm[1] && !degradeAlarm[0] |=> $stable(trafficOnProtect)[*3])
        else $error("manual switch onto faulty port");
endmodule
bind sapsc_controller sapsc_monitor #(.MINUTE_CYCLES(MINUTE_CYCLES)) i_sapsc_monitor (.core_clk, .rst,
    .rxBitValid, .rxBitError, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
    .trafficOnProtect, .degradeAlarm, .failureAlarm, .irq);

/* test/tb_top.sv */
// Purpose: self-checking bench of the protection switch controller
// Assumes: minute shortened to 50 cycles, rate window of 64 bits
// Notes: register and reset drives change after a rising edge, errEn after a falling one; results read at falling edges
`timescale 1ns/1ps
module tb_top;
    logic core_clk = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWrData = 32'h0, regRdData, v;
    logic [1:0] errEn = 2'h0, rxBitValid, rxBitError, degradeAlarm, failureAlarm;
    logic trafficOnProtect, irq;
    int fail_count = 0, checks_done = 0, n;
    always #2 core_clk = ~core_clk;
    sapsc_controller #(.MINUTE_CYCLES(50), .WINDOW_EXP(6)) i_sapsc_controller (.core_clk, .rst, .rxBitValid,
        .rxBitError, .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .trafficOnProtect, .degradeAlarm,
        .failureAlarm, .irq);
    sapsc_line_model i_sapsc_line_model (.core_clk, .rst, .errEn, .rxBitValid, .rxBitError);
    ////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
        @(negedge core_clk);
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        @(negedge core_clk);
        v = regRdData;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge core_clk);
    endtask
    task automatic wait_al(input int p, input logic lvl);
        n = 0;
        while (degradeAlarm[p] !== lvl && n < 600) begin
            @(negedge core_clk);
            n++;
        end
        chk("degrade alarm", 32'(lvl), 32'(degradeAlarm[p]));
    endtask
    task automatic rst_dut();
        @(posedge core_clk);
        rst <= 1'b1;
        errEn <= 2'h0;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_defaults();
        rst_dut();
        rd(4'h2); chk("restore", 32'h5, v);
        rd(4'h3); chk("degrade n", 32'h6, v);
        rd(4'h4); chk("failure n", 32'h3, v);
        rd(4'hF); chk("unmapped", 32'h0, v);
        wr(4'h2, 32'hF); rd(4'h2); chk("restore max", 32'hC, v);
        wr(4'h3, 32'h9); rd(4'h3); chk("degrade max", 32'h9, v);
        wr(4'h4, 32'h5); rd(4'h4); chk("failure max", 32'h5, v);
        $display("test defaults done");
    endtask
    task automatic t_fault();
        rst_dut();
        wr(4'h9, 32'h4);
        errEn <= 2'h1;
        wait_al(0, 1'b1);
        chk("failure alarm", 32'h1, 32'(failureAlarm[0]));
        cyc(2); chk("on protect", 32'h1, 32'(trafficOnProtect));
        chk("irq masked", 32'h0, 32'(irq));
        rd(4'h7); chk("events", 32'h3, v & 32'h3);
        wr(4'h9, 32'h1); cyc(1); chk("irq raised", 32'h1, 32'(irq));
        rd(4'h5); chk("status side", 32'h1, 32'(v[5]));
        errEn <= 2'h0;
        wait_al(0, 1'b0);
        wr(4'h8, 32'h1F); cyc(1); chk("irq cleared", 32'h0, 32'(irq));
        cyc(400); chk("stays protect", 32'h1, 32'(trafficOnProtect));
        $display("test fault done");
    endtask
    task automatic t_revert();
        rst_dut();
        wr(4'h0, 32'h1);
        wr(4'h2, 32'h6);
        errEn <= 2'h1;
        wait_al(0, 1'b1);
        errEn <= 2'h0;
        wait_al(0, 1'b0);
        n = 0;
        while (trafficOnProtect === 1'b1 && n < 500) begin
            @(negedge core_clk);
            n++;
        end
        chk("restore wait ok", 32'h1, 32'(n >= 296 && n <= 306));
        rd(4'hA);
        chk("minutes waited", 32'h6, v);
        rd(4'h7);
        chk("restored event", 32'h10, v & 32'h10);
        $display("test revert done");
    endtask
    task automatic t_lockout();
        rst_dut();
        wr(4'h1, 32'h01);
        errEn <= 2'h1;
        wait_al(0, 1'b1);
        cyc(2); chk("lock on working", 32'h1, 32'(trafficOnProtect));
        rst_dut();
        wr(4'h1, 32'h11);
        wr(4'h1, 32'h02);
        cyc(3); chk("lock beats forced", 32'h0, 32'(trafficOnProtect));
        errEn <= 2'h1;
        wait_al(0, 1'b1);
        cyc(3); chk("locked out", 32'h0, 32'(trafficOnProtect));
        wr(4'h1, 32'h08);
        cyc(3);
        chk("lockout cleared", 32'h1, 32'(trafficOnProtect));
        $display("test lockout done");
    endtask
    task automatic t_cmds();
        rst_dut();
        wr(4'h1, 32'h04);
        cyc(3); chk("manual clean", 32'h1, 32'(trafficOnProtect));
        rst_dut();
        errEn <= 2'h2;
        wait_al(1, 1'b1);
        chk("protect failure", 32'h1, 32'(failureAlarm[1]));
        rd(4'h6);
        chk("alarm word", 32'hA, v);
        wr(4'h1, 32'h04);
        cyc(3); chk("manual dirty", 32'h0, 32'(trafficOnProtect));
        wr(4'h1, 32'h02);
        cyc(3); chk("forced", 32'h1, 32'(trafficOnProtect));
        $display("test commands done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        t_defaults();
        t_fault();
        t_revert();
        t_lockout();
        t_cmds();
        close_out();
    end
    // watchdog well beyond the expected run of some 1600 cycles
    initial begin
        #200000;
        fail_count++;
        close_out();
    end
endmodule

/* verilog/sapsc_controller.sv */
// Purpose: 1+1 protection switching controller for a working and a protecting line port
// Assumes: error and bit strobes come from the two framers, synchronous to core_clk
// Notes: the selected port drives traffic; thresholds and timers set over the register port
// Notes: alarms and fault switching act on whole rate windows, judged at each window end, not as each error arrives
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "sapsc_map.svh"
module sapsc_controller #(
    // a minute of core clocks runs past 32 bits, so the count is 64 bits wide
    parameter longint unsigned MINUTE_CYCLES = 64'(`SAPSC_CLK_HZ) * 64'(`SAPSC_SECONDS_PER_MINUTE),
    parameter int unsigned WINDOW_EXP = `SAPSC_BER_WINDOW_EXP
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // received bit and bit error strobes, index 0 working, 1 protecting
    input wire logic [1:0] rxBitValid,
    input wire logic [1:0] rxBitError,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdData,
    // switching result
    output logic trafficOnProtect,
    output logic [1:0] degradeAlarm,
    output logic [1:0] failureAlarm,
    output logic irq
);
    import sapsc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state: all of it sits in one struct, so that reset and the register step
    // each touch it in one place only
    typedef struct packed {
        logic revertive;
        logic lockout;
        logic forced;
        logic manual;
        logic [3:0] restoreMin;
        logic [3:0] degradeN;
        logic [3:0] failureN;
        sapsc_state_t state;
        logic [63:0] cycleCnt;
        logic [3:0] minuteCnt;
        logic [1:0][31:0] bitCnt;
        logic [1:0][31:0] errCnt;
        logic [1:0][31:0] lastErr;
        logic [1:0] degrade;
        logic [1:0] failure;
        logic [4:0] evt;
        logic [4:0] evtEn;
        logic [31:0] rdData;
        logic onProtect;
        logic irq;
    } sapsc_regs_t;

    sapsc_regs_t r_q, r_d;
    sapsc_req_t req;

    ////////////////////////////////////////////////////////////////////////
    // errors needed within the window to meet ten to the minus n
    // a short window rounds the limit up to one error, so both alarms may share
    // a limit then; the failure limit can never fall below the degrade one
    function automatic logic [31:0] errLimit(input logic [3:0] n);
        logic [31:0] w;
        w = 32'h1 << WINDOW_EXP;
        for (int i = 0; i < 16; i++) begin
            if (i < n) begin
                w = w / 32'hA;
            end
        end
        return (w == 32'h0) ? 32'h1 : w;
    endfunction

    // clamp a written value into its programmable range
    // out-of-range writes are clamped, not refused, so the field is always legal
    function automatic logic [3:0] clampN(input logic [3:0] v, input logic [3:0] lo, input logic [3:0] hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        // scratch values, each given a value before any use
        logic anyFault;
        logic protClean;
        logic [4:0] evtSet;
        logic [1:0] newDeg;
        logic [1:0] newFail;
        anyFault = 1'b0;
        protClean = 1'b0;
        evtSet = 5'h0;
        newDeg = 2'h0;
        newFail = 2'h0;
        r_d = r_q;
        r_d.rdData = 32'h0;

        // fixed window per port: counts restart each window, rate judged at the end
        // judging only at the window end keeps one error burst from chattering the alarm
        for (int p = 0; p < 2; p++) begin
            if (rxBitValid[p]) begin
                if (r_q.bitCnt[p] == (32'h1 << WINDOW_EXP) - 32'h1) begin // see R15
                    r_d.lastErr[p] = r_q.errCnt[p] + {31'h0, rxBitError[p]};
                    r_d.bitCnt[p] = 32'h0;
                    r_d.errCnt[p] = 32'h0;
                end else begin
                    r_d.bitCnt[p] = r_q.bitCnt[p] + 32'h1;
                    r_d.errCnt[p] = r_q.errCnt[p] + {31'h0, rxBitError[p]};
                end
            end
            // failure limit is never below degrade limit, so degrade is met no later than failure; see R13
            newDeg[p] = r_d.lastErr[p] >= errLimit(r_q.degradeN); // see R11
            newFail[p] = r_d.lastErr[p] >= errLimit(r_q.failureN); // see R12
            r_d.degrade[p] = newDeg[p] | newFail[p];
            r_d.failure[p] = newFail[p];
        end
        evtSet[0] = r_d.degrade[0] & ~r_q.degrade[0];
        evtSet[1] = r_d.failure[0] & ~r_q.failure[0];
        evtSet[2] = r_d.degrade[1] & ~r_q.degrade[1];
        evtSet[3] = r_d.failure[1] & ~r_q.failure[1];

        anyFault = r_q.degrade[0] | r_q.failure[0]; // see R2
        protClean = ~r_q.degrade[1] & ~r_q.failure[1];

        // priority resolution of competing requests
        // only the top request acts in a cycle; lower ones stay pending, except manual, which an acting fault clears
        if (r_q.lockout) begin // see R16
            req = SAPSC_REQ_LOCKOUT;
        end else if (r_q.forced) begin
            req = SAPSC_REQ_FORCED;
        end else if (r_q.failure[0]) begin
            req = SAPSC_REQ_FAILURE;
        end else if (r_q.degrade[0]) begin
            req = SAPSC_REQ_DEGRADE;
        end else if (r_q.manual) begin
            req = SAPSC_REQ_MANUAL;
        end else if (r_q.state == SAPSC_WAITING) begin
            req = SAPSC_REQ_RESTORE;
        end else begin
            req = SAPSC_REQ_NONE;
        end

        // one working and one protecting port, traffic on exactly one; see R1
        case (req)
            SAPSC_REQ_LOCKOUT: begin
                // lockout parks traffic on the working port
                r_d.state = SAPSC_ON_WORKING; // see R3
            end
            SAPSC_REQ_FORCED: begin
                // forced is consumed once acted on, so it toggles a single time
                r_d.state = r_q.onProtect ? SAPSC_ON_WORKING : SAPSC_ON_PROTECT; // see R4
                r_d.forced = 1'b0;
            end
            SAPSC_REQ_FAILURE, SAPSC_REQ_DEGRADE: begin
                r_d.state = SAPSC_ON_PROTECT; // see R2
                r_d.manual = 1'b0;
            end
            SAPSC_REQ_MANUAL: begin
                // a refused manual request is dropped, not held
                if (protClean) begin // see R5
                    r_d.state = r_q.onProtect ? SAPSC_ON_WORKING : SAPSC_ON_PROTECT;
                end
                r_d.manual = 1'b0;
            end
            default: begin
                r_d.state = r_q.state;
            end
        endcase

        // return path after the fault clears
        // the wait starts only with nothing pending, so a new fault drops the count and the full wait
        // starts over once the port is clean again; a forced, lockout or accepted manual command ends it on the working port
        case (r_q.state)
            SAPSC_ON_PROTECT: begin
                if (!anyFault && r_q.revertive && r_d.state == SAPSC_ON_PROTECT && r_q.onProtect
                        && (req == SAPSC_REQ_NONE)) begin // see R7
                    r_d.state = SAPSC_WAITING; // see R8
                    r_d.cycleCnt = 64'h0;
                    r_d.minuteCnt = 4'h0;
                end
            end
            SAPSC_WAITING: begin
                if (req == SAPSC_REQ_RESTORE) begin
                    if (!r_q.revertive) begin
                        r_d.state = SAPSC_ON_PROTECT; // see R6
                    end else if (r_q.cycleCnt == MINUTE_CYCLES - 64'h1) begin
                        // minutes are counted whole, so the wait never ends early
                        r_d.cycleCnt = 64'h0;
                        r_d.minuteCnt = r_q.minuteCnt + 4'h1;
                        if (r_q.minuteCnt + 4'h1 >= r_q.restoreMin) begin // see R7
                            r_d.state = SAPSC_ON_WORKING;
                            evtSet[4] = 1'b1;
                        end
                    end else begin
                        r_d.cycleCnt = r_q.cycleCnt + 64'h1;
                    end
                end
            end
            default: begin
            end
        endcase
        r_d.onProtect = (r_d.state != SAPSC_ON_WORKING);

        // register writes
        // unmapped writes are dropped; read-only registers ignore writes
        if (regWrite) begin
            case (regAddr)
                `SAPSC_REG_CTRL: begin
                    r_d.revertive = regWrData[`SAPSC_CTRL_REVERT];
                end
                `SAPSC_REG_CMD: begin
                    // lockout only accepted on the protecting port; see R3
                    // one addressed to the working port is dropped without trace
                    if (regWrData[`SAPSC_CMD_LOCKOUT] && regWrData[`SAPSC_CMD_PROT_PORT]) begin
                        r_d.lockout = 1'b1;
                    end
                    if (regWrData[`SAPSC_CMD_FORCED]) begin
                        r_d.forced = 1'b1;
                    end
                    if (regWrData[`SAPSC_CMD_MANUAL]) begin
                        r_d.manual = 1'b1;
                    end
                    if (regWrData[`SAPSC_CMD_CLEAR]) begin
                        r_d.lockout = 1'b0;
                        r_d.forced = 1'b0;
                        r_d.manual = 1'b0;
                    end
                end
                `SAPSC_REG_RESTORE: begin
                    r_d.restoreMin = clampN(regWrData[3:0], `SAPSC_RESTORE_MIN, `SAPSC_RESTORE_MAX); // see R8
                end
                `SAPSC_REG_DEGRADE: begin
                    r_d.degradeN = clampN(regWrData[3:0], `SAPSC_DEGRADE_MIN, `SAPSC_DEGRADE_MAX); // see R9
                end
                `SAPSC_REG_FAILURE: begin
                    r_d.failureN = clampN(regWrData[3:0], `SAPSC_FAILURE_MIN, `SAPSC_FAILURE_MAX); // see R10
                end
                `SAPSC_REG_EVT_EN: begin
                    r_d.evtEn = regWrData[4:0];
                end
                default: begin
                end
            endcase
        end

        // sticky events, set wins over clear
        // so an event landing on the clear write is never lost
        if (regWrite && regAddr == `SAPSC_REG_EVT_CLR) begin
            r_d.evt = (r_q.evt & ~regWrData[4:0]) | evtSet;
        end else begin
            r_d.evt = r_q.evt | evtSet;
        end
        r_d.irq = |(r_d.evt & r_d.evtEn);

        // register reads, data in the following cycle
        // the read word is zero outside that cycle, so no stale value lingers
        if (regRead) begin
            case (regAddr)
                `SAPSC_REG_CTRL: r_d.rdData = {31'h0, r_q.revertive};
                `SAPSC_REG_CMD: r_d.rdData = {29'h0, r_q.manual, r_q.forced, r_q.lockout};
                `SAPSC_REG_RESTORE: r_d.rdData = {28'h0, r_q.restoreMin};
                `SAPSC_REG_DEGRADE: r_d.rdData = {28'h0, r_q.degradeN};
                `SAPSC_REG_FAILURE: r_d.rdData = {28'h0, r_q.failureN};
                // level 1+1, unidirectional, role per port, switch state; see R14
                `SAPSC_REG_STATUS: begin
                    r_d.rdData = {24'h0,
                                  2'(r_q.state), // switch state
                                  r_q.onProtect, // traffic side
                                  1'b0, // unidirectional
                                  1'b1, 1'b0, 1'b1, 1'b1}; // level and roles
                end
                `SAPSC_REG_ALARM: r_d.rdData = {28'h0, r_q.failure, r_q.degrade};
                `SAPSC_REG_EVT: r_d.rdData = {27'h0, r_q.evt};
                `SAPSC_REG_EVT_EN: r_d.rdData = {27'h0, r_q.evtEn};
                `SAPSC_REG_WAITLEFT: r_d.rdData = {28'h0, r_q.minuteCnt};
                default: r_d.rdData = 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    // reset zeroes every field, then loads the programmable fields with defaults
    always_ff @(posedge core_clk) begin
        if (rst) begin
            r_q <= '0;
            r_q.restoreMin <= `SAPSC_RESTORE_DEF;
            r_q.degradeN <= `SAPSC_DEGRADE_DEF;
            r_q.failureN <= `SAPSC_FAILURE_DEF;
            r_q.state <= SAPSC_ON_WORKING;
        end else begin
            r_q <= r_d;
        end
    end

    // outputs straight from flip-flops
    // no logic between the state and the pins, so outputs never glitch
    assign regRdData = r_q.rdData;
    assign trafficOnProtect = r_q.onProtect;
    assign degradeAlarm = r_q.degrade;
    assign failureAlarm = r_q.failure;
    assign irq = r_q.irq;
endmodule
